// ### phy_mgmt_regs.sv
// base management registers behind the serial management pins
// Function
// - all base registers sixteen bits, whole word
// - addresses 0 to 8 live, 9 to 15 absent
// - speed, autoneg, duplex defaults from straps
// - isolate bit disconnects from media interface
// - writing one restarts auto-negotiation
// - status bits 14 to 11 read one
// - status bits 15, 10, 9 read zero
// - status bit 8 reads zero
// - no preamble suppression; full preamble needed
// - status bit 5 shows negotiation complete
// - remote fault latches high until read
// - status bit 3 reads one
// - jabber latches high until read
// - status bit 0 reads one
// - first identifier register read-only
`timescale 1ns/1ns
`include "phy_mgmt_params.svh"
module phy_mgmt_regs
    import phy_mgmt_pkg::*;
#(
    parameter logic [15:0] ID_HIGH = 16'h5a5a, // arbitrary identifier
    parameter logic [15:0] ID_LOW  = 16'ha5a0  // arbitrary identifier
)
(
    input  wire logic          clk,         // core clock, 250 MHz
    input  wire logic          rst,         // async reset, active high
    input  wire logic          mdc,         // management clock pin
    input  wire logic          mdio_in,     // management data pin level
    output logic               mdio_out,    // management data drive
    output logic               mdio_oe_n,   // low while driving mdio
    input  wire logic [4:0]    phy_addr,    // address strap pins
    input  wire strap_t        strap,       // default strap pins
    input  wire line_status_t  line_status, // live line conditions
    input  wire partner_regs_t partner,     // negotiation results
    output phy_ctrl_t          ctrl,        // control settings
    output logic [15:0]        advertise,   // advertised abilities
    output logic [15:0]        next_page,   // next page to transmit
    output logic               an_restart,  // one-cycle restart pulse
    output logic               soft_reset   // one-cycle reset pulse
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    pin_in_t     pins_raw;
    pin_in_t     pins;
    mgmt_state_t state_reg;
    mgmt_state_t state_next;
    logic        mdc_rise;
    logic [13:0] header;
    logic [15:0] write_word;
    logic [15:0] read_word;
    logic [15:0] status_word;

    // collect pins into one bundle for the synchroniser
    always_comb begin
        pins_raw.mdc      = mdc;
        pins_raw.mdio     = mdio_in;
        pins_raw.phy_addr = phy_addr;
        pins_raw.strap    = strap;
    end

    pin_sync i_pin_sync (
        .clk       (clk),
        .rst       (rst),
        .pins      (pins_raw),
        .pins_sync (pins)
    );

    // ------------------------------------------------------------
    // frame fields and status word
    // ------------------------------------------------------------

    // management clock edge seen through the synchroniser
    assign mdc_rise   = pins.mdc & ~state_reg.mdc_prev;
    assign header     = {state_reg.shift[12:0], pins.mdio};
    assign write_word = {state_reg.shift[14:0], pins.mdio};

    // status word: fixed abilities plus live and latched bits
    always_comb begin
        status_word = `STS_FIXED;
        // bits 15, 10, 9, 8, 7 and 6 stay zero
        // bits 3 and 0 come from the fixed pattern
        status_word[`STS_AN_DONE]      = line_status.an_done;
        status_word[`STS_REMOTE_FAULT] = state_reg.lh_remote_fault;
        status_word[`STS_LINK]         = state_reg.ll_link;
        status_word[`STS_JABBER]       = state_reg.lh_jabber;
    end

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------

    // unimplemented addresses read as zero
    always_comb begin
        case (state_reg.reg_addr)
            `REG_CONTROL: begin
                read_word = state_reg.control;      // self-clear bits read 0
            end
            `REG_STATUS: begin
                read_word = status_word;
            end
            `REG_ID_HIGH: begin
                read_word = ID_HIGH;
            end
            `REG_ID_LOW: begin
                read_word = ID_LOW;
            end
            `REG_ADVERTISE: begin
                read_word = state_reg.advertise;
            end
            `REG_PARTNER_BASE: begin
                read_word = partner.base;
            end
            `REG_EXPANSION: begin
                read_word = partner.expansion;
            end
            `REG_NEXT_PAGE_TX: begin
                read_word = state_reg.next_page;
            end
            `REG_PARTNER_NP: begin
                read_word = partner.next_page;
            end
            default: begin
                read_word = 16'h0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state: straps, latches, frame engine, register writes
    // ------------------------------------------------------------
    always_comb begin
        state_next            = state_reg;
        state_next.an_restart = 1'b0;
        state_next.soft_reset = 1'b0;
        state_next.mdc_prev   = pins.mdc;

        // sticky events; the set is applied every cycle, but a soft reset clear in the same cycle overrides it
        if (line_status.remote_fault) begin
            state_next.lh_remote_fault = 1'b1;
        end
        if (line_status.jabber) begin
            state_next.lh_jabber = 1'b1;
        end
        if (!line_status.link_up) begin
            state_next.ll_link = 1'b0;
        end

        // capture straps once the synchroniser holds valid levels
        if (state_reg.init_cnt != `STRAP_READY) begin
            state_next.init_cnt = state_reg.init_cnt + 2'd1;
            if (state_reg.init_cnt == `STRAP_CAPTURE) begin
                state_next.strap    = pins.strap;
                state_next.phy_addr = pins.phy_addr;
                state_next.control  = 16'h0000;
                state_next.control[`CTL_SPEED_LSB] = pins.strap.speed;
                state_next.control[`CTL_AN_ENABLE] = pins.strap.an_enable;
                state_next.control[`CTL_DUPLEX]    = pins.strap.duplex;
            end
        end else if (mdc_rise) begin
            case (state_reg.fsm)
                // count ones; a zero after a full preamble starts a frame
                ST_PREAMBLE: begin
                    if (pins.mdio) begin
                        if (state_reg.cnt != `PREAMBLE_BITS) begin
                            state_next.cnt = state_reg.cnt + 6'd1;
                        end
                    end else if (state_reg.cnt == `PREAMBLE_BITS) begin
                        state_next.fsm   = ST_HEADER;
                        state_next.cnt   = 6'd1;
                        state_next.shift = 16'h0000;
                    end else begin
                        state_next.cnt = 6'd0;
                    end
                end
                // start code, opcode, phy address, register address
                ST_HEADER: begin
                    state_next.shift = {state_reg.shift[14:0], pins.mdio};
                    state_next.cnt   = state_reg.cnt + 6'd1;
                    if (state_reg.cnt == `HEADER_LAST) begin
                        state_next.cnt      = 6'd0;
                        state_next.reg_addr = header[4:0];
                        state_next.fsm      = ST_PREAMBLE;
                        if (header[13:12] == `START_CODE &&
                            header[9:5] == state_reg.phy_addr) begin
                            if (header[11:10] == `OP_READ) begin
                                state_next.fsm = ST_RD_TA;
                            end else if (header[11:10] == `OP_WRITE) begin
                                state_next.fsm = ST_WR_TA;
                            end
                        end
                    end
                end
                // drive the second turnaround bit low, load read data
                ST_RD_TA: begin
                    state_next.mdio_out  = 1'b0;
                    state_next.mdio_oe_n = 1'b0;
                    state_next.shift     = read_word;
                    state_next.cnt       = 6'd0;
                    state_next.fsm       = ST_RD_DATA;
                    // read clears latches to the present condition
                    if (state_reg.reg_addr == `REG_STATUS) begin
                        state_next.lh_remote_fault =
                            line_status.remote_fault;
                        state_next.lh_jabber = line_status.jabber;
                        state_next.ll_link   = line_status.link_up;
                    end
                end
                // shift sixteen bits out, msb first, then release
                ST_RD_DATA: begin
                    state_next.cnt = state_reg.cnt + 6'd1;
                    if (state_reg.cnt == `DATA_DONE) begin
                        state_next.mdio_out  = 1'b1;
                        state_next.mdio_oe_n = 1'b1;
                        state_next.cnt       = 6'd0;
                        state_next.fsm       = ST_PREAMBLE;
                    end else begin
                        state_next.mdio_out = state_reg.shift[15];
                        state_next.shift    = {state_reg.shift[14:0], 1'b0};
                    end
                end
                // skip the two turnaround bits of a write
                ST_WR_TA: begin
                    state_next.cnt = state_reg.cnt + 6'd1;
                    if (state_reg.cnt == 6'd1) begin
                        state_next.cnt = 6'd0;
                        state_next.fsm = ST_WR_DATA;
                    end
                end
                // collect the data word and commit it whole
                ST_WR_DATA: begin
                    state_next.shift = write_word;
                    state_next.cnt   = state_reg.cnt + 6'd1;
                    if (state_reg.cnt == `DATA_LAST) begin
                        state_next.cnt = 6'd0;
                        state_next.fsm = ST_PREAMBLE;
                        case (state_reg.reg_addr)
                            `REG_CONTROL: begin
                                if (write_word[`CTL_RESET]) begin
                                    // soft reset reloads every default
                                    state_next.soft_reset = 1'b1;
                                    state_next.control    = 16'h0000;
                                    state_next.control[`CTL_SPEED_LSB] =
                                        state_reg.strap.speed;
                                    state_next.control[`CTL_AN_ENABLE] =
                                        state_reg.strap.an_enable;
                                    state_next.control[`CTL_DUPLEX] =
                                        state_reg.strap.duplex;
                                    state_next.advertise = `ADV_RESET;
                                    state_next.next_page = `NEXT_PAGE_RESET;
                                    state_next.lh_remote_fault = 1'b0;
                                    state_next.lh_jabber       = 1'b0;
                                    state_next.ll_link         = 1'b0;
                                end else begin
                                    state_next.control =
                                        write_word & `CTL_STORE_MASK;
                                    state_next.an_restart =
                                        write_word[`CTL_AN_RESTART];
                                end
                            end
                            `REG_ADVERTISE: begin
                                state_next.advertise =
                                    write_word & `ADV_WRITE_MASK;
                            end
                            `REG_NEXT_PAGE_TX: begin
                                state_next.next_page = write_word;
                            end
                            default: begin
                                // read-only and absent registers ignore
                                state_next.next_page = state_reg.next_page;
                            end
                        endcase
                    end
                end
                default: begin
                    state_next.fsm = ST_PREAMBLE;
                    state_next.cnt = 6'd0;
                end
            endcase
        end

        // decoded control outputs follow the stored control word
        state_next.ctrl.loopback =
            state_next.control[`CTL_LOOPBACK];
        state_next.ctrl.speed_100 =
            state_next.control[`CTL_SPEED_LSB] &
            ~state_next.control[`CTL_SPEED_MSB];
        state_next.ctrl.an_enable =
            state_next.control[`CTL_AN_ENABLE];
        state_next.ctrl.power_down =
            state_next.control[`CTL_POWER_DOWN];
        state_next.ctrl.isolate =
            state_next.control[`CTL_ISOLATE];
        state_next.ctrl.full_duplex =
            state_next.control[`CTL_DUPLEX];
        state_next.ctrl.collision_test =
            state_next.control[`CTL_COLL_TEST];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    // reset puts the pin released and all registers at rest
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.fsm       <= ST_PREAMBLE;
            state_reg.mdio_out  <= 1'b1;
            state_reg.mdio_oe_n <= 1'b1;
            state_reg.advertise <= `ADV_RESET;
            state_reg.next_page <= `NEXT_PAGE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------
    assign mdio_out   = state_reg.mdio_out;
    assign mdio_oe_n  = state_reg.mdio_oe_n;
    assign ctrl       = state_reg.ctrl;
    assign advertise  = state_reg.advertise;
    assign next_page  = state_reg.next_page;
    assign an_restart = state_reg.an_restart;
    assign soft_reset = state_reg.soft_reset;

endmodule : phy_mgmt_regs

// ### phy_mgmt_params.svh
// constants for the phy base management register set
`ifndef PHY_MGMT_PARAMS_SVH
`define PHY_MGMT_PARAMS_SVH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define REG_CONTROL      5'h00
`define REG_STATUS       5'h01
`define REG_ID_HIGH      5'h02
`define REG_ID_LOW       5'h03
`define REG_ADVERTISE    5'h04
`define REG_PARTNER_BASE 5'h05
`define REG_EXPANSION    5'h06
`define REG_NEXT_PAGE_TX 5'h07
`define REG_PARTNER_NP   5'h08

// ------------------------------------------------------------
// control field positions and masks
// ------------------------------------------------------------
`define CTL_RESET        15
`define CTL_LOOPBACK     14
`define CTL_SPEED_LSB    13
`define CTL_AN_ENABLE    12
`define CTL_POWER_DOWN   11
`define CTL_ISOLATE      10
`define CTL_AN_RESTART   9
`define CTL_DUPLEX       8
`define CTL_COLL_TEST    7
`define CTL_SPEED_MSB    6
`define CTL_STORE_MASK   16'h7dc0

// ------------------------------------------------------------
// status field positions and fixed ability bits
// ------------------------------------------------------------
`define STS_FIXED        16'h7809
`define STS_AN_DONE      5
`define STS_REMOTE_FAULT 4
`define STS_LINK         2
`define STS_JABBER       1

// ------------------------------------------------------------
// reset values and write masks
// ------------------------------------------------------------
`define ADV_RESET        16'h01e1
`define ADV_WRITE_MASK   16'hbfff
`define NEXT_PAGE_RESET  16'h0000

// ------------------------------------------------------------
// frame layout and start-up timing
// ------------------------------------------------------------
`define PREAMBLE_BITS    6'd32
`define HEADER_LAST      6'd13
`define DATA_LAST        6'd15
`define DATA_DONE        6'd16
`define START_CODE       2'b01
`define OP_READ          2'b10
`define OP_WRITE         2'b01
`define STRAP_CAPTURE    2'd2
`define STRAP_READY      2'd3

`endif

// ### phy_mgmt_pkg.sv
// types shared by the phy management register set
package phy_mgmt_pkg;

    typedef enum logic [2:0] {
        ST_PREAMBLE = 3'b000,
        ST_HEADER   = 3'b001,
        ST_RD_TA    = 3'b010,
        ST_RD_DATA  = 3'b011,
        ST_WR_TA    = 3'b100,
        ST_WR_DATA  = 3'b101
    } frame_state_t;

    typedef struct packed {
        logic speed;
        logic an_enable;
        logic duplex;
    } strap_t;

    typedef struct packed {
        logic       mdc;
        logic       mdio;
        logic [4:0] phy_addr;
        strap_t     strap;
    } pin_in_t;

    typedef struct packed {
        pin_in_t stage1;
        pin_in_t stage2;
    } sync_state_t;

    typedef struct packed {
        logic link_up;
        logic remote_fault;
        logic jabber;
        logic an_done;
    } line_status_t;

    typedef struct packed {
        logic [15:0] base;
        logic [15:0] expansion;
        logic [15:0] next_page;
    } partner_regs_t;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic an_enable;
        logic power_down;
        logic isolate;
        logic full_duplex;
        logic collision_test;
    } phy_ctrl_t;

    typedef struct packed {
        frame_state_t fsm;
        logic [5:0]   cnt;
        logic [15:0]  shift;
        logic [4:0]   reg_addr;
        logic         mdc_prev;
        logic         mdio_out;
        logic         mdio_oe_n;
        logic [15:0]  control;
        logic [15:0]  advertise;
        logic [15:0]  next_page;
        logic         lh_remote_fault;
        logic         lh_jabber;
        logic         ll_link;
        logic         an_restart;
        logic         soft_reset;
        logic [1:0]   init_cnt;
        strap_t       strap;
        logic [4:0]   phy_addr;
        phy_ctrl_t    ctrl;
    } mgmt_state_t;

endpackage : phy_mgmt_pkg

// ### pin_sync.sv
// two-stage synchroniser for all pins from outside the clock domain
`timescale 1ns/1ns
module pin_sync
    import phy_mgmt_pkg::*;
(
    input  wire logic    clk,      // core clock
    input  wire logic    rst,      // async reset, active high
    input  wire pin_in_t pins,     // raw pin levels
    output pin_in_t      pins_sync // pin levels after two flops
);

    sync_state_t state_reg;
    sync_state_t state_next;

    // first stage feeds only the second stage
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = pins;
        state_next.stage2 = state_reg.stage1;
    end

    // register both stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pins_sync = state_reg.stage2;

endmodule : pin_sync

// ### phy_mgmt_regs_chk.sv
// port assertions for the management register set
`timescale 1ns/1ns
`include "phy_mgmt_params.svh"
module phy_mgmt_regs_chk
    import phy_mgmt_pkg::*;
(
    input wire logic        clk,        // core clock
    input wire logic        rst,        // async reset
    input wire logic        mdc,        // management clock pin
    input wire logic        mdio_out,   // data drive value
    input wire logic        mdio_oe_n,  // drive enable, low active
    input wire strap_t      strap,      // default strap pins
    input wire phy_ctrl_t   ctrl,       // control outputs
    input wire logic [15:0] advertise,  // register 4
    input wire logic [15:0] next_page,  // register 7
    input wire logic        an_restart, // restart pulse
    input wire logic        soft_reset  // reset pulse
);
    logic [8:0] low_cnt; // cycles with mdio driven

    // ------------------------------------------------------------
    // drive length counter and assertions
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_cnt <= 9'h000;
        else
            low_cnt <= mdio_oe_n ? 9'h000 : low_cnt + 9'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence drive_start;
        $fell(mdio_oe_n);
    endsequence
    sequence ta_low;
        !mdio_out [*8];
    endsequence
    a_ta_drives_zero: assert property (drive_start |-> ta_low)
        else $error("turnaround bit not driven low");
    a_read_length: assert property ($rose(mdio_oe_n) |->
        low_cnt >= 9'd268 && low_cnt <= 9'd276)
        else $error("read drive not seventeen bit times");
    a_idle_high: assert property (mdio_oe_n |-> mdio_out)
        else $error("undriven data not at idle level");
    a_restart_once: assert property (an_restart |->
        mdc ##1 !an_restart)
        else $error("restart pulse outside write commit");
    a_reset_once: assert property (soft_reset |-> mdc ##1 !soft_reset)
        else $error("reset pulse outside write commit");
    a_reset_reload: assert property (soft_reset |-> ##[1:2]
        (!ctrl.isolate && !ctrl.loopback && !ctrl.power_down &&
         advertise == `ADV_RESET && next_page == `NEXT_PAGE_RESET))
        else $error("soft reset did not reload registers");
    a_strap_load: assert property ($fell(rst) |-> ##[2:4]
        (ctrl.speed_100 == strap.speed && ctrl.an_enable == strap.an_enable
         && ctrl.full_duplex == strap.duplex))
        else $error("control defaults differ from straps");
    a_adv_commit: assert property ($changed(advertise) |-> mdc)
        else $error("advertise changed outside write commit");
    a_np_commit: assert property ($changed(next_page) |-> mdc)
        else $error("next page changed outside write commit");
endmodule : phy_mgmt_regs_chk
bind phy_mgmt_regs phy_mgmt_regs_chk i_phy_mgmt_regs_chk (.clk, .rst, .mdc,
    .mdio_out, .mdio_oe_n, .strap, .ctrl, .advertise, .next_page,
    .an_restart, .soft_reset);

// ### mgmt_station.sv
// station manager model driving the serial management pins
`timescale 1ns/1ns
`include "phy_mgmt_params.svh"
module mgmt_station (
    output logic      mdc,     // management clock, still between frames
    output logic      drv,     // level the station drives
    output logic      drv_en,  // station drives the data wire
    input  wire logic wire_lvl // resolved data wire level
);
    // ------------------------------------------------------------
    // frame generator, 64 ns bit period
    // ------------------------------------------------------------
    initial begin
        mdc = 1'b0;
        drv = 1'b1;
        drv_en = 1'b0;
    end
    task automatic frame(input int pre, input logic [1:0] op,
        input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [31:0] h;
        h = {`START_CODE, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = pre + 31; i >= 0; i--) begin
            drv_en = !(op == `OP_READ && i < 18); // release for turnaround
            drv = (i > 31) || h[i];
            #32 mdc = 1'b1;
            if (i < 16)
                rd[i] = wire_lvl;
            #32 mdc = 1'b0;
        end
        drv_en = 1'b0;
        #32; // idle gap, next frame drives in a later step
    endtask : frame
endmodule : mgmt_station

// ### phy_mgmt_regs_tb.sv
// self-checking bench for the management register set
`timescale 1ns/1ns
`include "phy_mgmt_params.svh"
module phy_mgmt_regs_tb
    import phy_mgmt_pkg::*;
;
    localparam logic [4:0]  PA   = 5'h0b;
    localparam strap_t      STRAP = 3'b100;
    localparam logic [15:0] ID_H = 16'h3c69; // arbitrary identifier
    logic          clk, rst, mdc, mdio_in, mdio_out, mdio_oe_n, drv, drv_en;
    logic          an_restart, soft_reset;
    line_status_t  ls;
    partner_regs_t pr;
    phy_ctrl_t     ctrl;
    logic [15:0]   adv, np, rd, w, ctl_m;
    logic [31:0]   seed;
    int            errors, checks_done, restarts, resets;

    // ------------------------------------------------------------
    // design, station model, pulled-up data wire
    // ------------------------------------------------------------
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'b1);
    phy_mgmt_regs #(.ID_HIGH(ID_H)) i_phy_mgmt_regs (.clk, .rst, .mdc,
        .mdio_in, .mdio_out, .mdio_oe_n, .phy_addr(PA), .strap(STRAP),
        .line_status(ls), .partner(pr), .ctrl, .advertise(adv),
        .next_page(np), .an_restart, .soft_reset);
    mgmt_station i_mgmt_station (.mdc, .drv, .drv_en, .wire_lvl(mdio_in));
    always @(posedge clk) begin
        restarts += (an_restart === 1'b1);
        resets += (soft_reset === 1'b1);
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #300000;
        errors++;
        test_done;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] exp_ctrl(input logic [15:0] c);
        return {9'h000, c[14], c[13] & ~c[6], c[12], c[11],
                c[10], c[8], c[7]};
    endfunction : exp_ctrl
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp);
        i_mgmt_station.frame(32, `OP_READ, PA, ra, 16'h0000, rd);
        chk(rd, exp);
    endtask : rdchk
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        i_mgmt_station.frame(32, `OP_WRITE, PA, ra, d, rd);
    endtask : wr
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ls = 4'b1000;
        pr = '0;
        seed = 32'h357c;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        rdchk(`REG_CONTROL, 16'h2000);
        rdchk(`REG_STATUS, 16'h7809);
        rdchk(`REG_STATUS, 16'h780d);
        ls = 4'b0110;
        repeat (4) @(negedge clk);
        ls = 4'b1000;
        rdchk(`REG_STATUS, 16'h781b);
        ls = 4'b1001;
        rdchk(`REG_STATUS, 16'h782d);
        wr(`REG_ID_HIGH, ~ID_H);
        rdchk(`REG_ID_HIGH, ID_H);
        seed = lfsr(seed);
        pr = {seed[15:0], seed[31:16], seed[15:0] ^ 16'h0f0f};
        rdchk(`REG_PARTNER_BASE, pr.base);
        rdchk(`REG_EXPANSION, pr.expansion);
        rdchk(`REG_PARTNER_NP, pr.next_page);
        wr(`REG_ADVERTISE, seed[15:0]);
        chk(adv, seed[15:0] & `ADV_WRITE_MASK);
        rdchk(`REG_ADVERTISE, seed[15:0] & `ADV_WRITE_MASK);
        wr(`REG_NEXT_PAGE_TX, seed[31:16]);
        chk(np, seed[31:16]);
        wr(5'h09, 16'hffff);
        for (int i = 9; i < 16; i++)
            rdchk(5'(i), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            w = seed[15:0] & 16'h1180;
            {w[14], w[13], w[11], w[10], w[9], w[6]} =
                {i[1], i[0], ~i[0], i[0] ^ i[1], 1'b1, i[1]};
            wr(`REG_CONTROL, w);
            ctl_m = w & `CTL_STORE_MASK;
            rdchk(`REG_CONTROL, ctl_m);
            chk(exp_ctrl(ctl_m), {9'h000, ctrl});
        end
        wr(`REG_CONTROL, 16'h8000);
        rdchk(`REG_CONTROL, 16'h2000);
        chk(adv, `ADV_RESET);
        chk(16'(resets), 16'h0001);
        chk(16'(restarts), 16'h0004);
        i_mgmt_station.frame(31, `OP_READ, PA, `REG_ID_HIGH, 16'h0000,
            rd);
        chk(rd, 16'hffff);
        rdchk(`REG_ID_HIGH, ID_H);
        test_done;
    end
endmodule : phy_mgmt_regs_tb
